// >>> inc/ums_params.svh
// Register offsets, field positions, reset values and widths of the modem status block
`ifndef UMS_PARAMS_SVH
`define UMS_PARAMS_SVH

`define UMS_ADDR_W 4
`define UMS_DATA_W 8

`define UMS_OFF_MCR 4'h4
`define UMS_OFF_MSR 4'h6
`define UMS_OFF_SPR 4'h7
`define UMS_OFF_DLL 4'h8
`define UMS_OFF_DLM 4'h9
`define UMS_OFF_MASK 4'hA
`define UMS_OFF_TXST 4'hB

`define UMS_MCR_DTR 0
`define UMS_MCR_RTS 1
`define UMS_MCR_OUT1 2
`define UMS_MCR_OUT2 3
`define UMS_MCR_LOOP 4
`define UMS_MCR_MASK 8'h1F

`define UMS_MSR_CTS 4
`define UMS_MSR_DSR 5
`define UMS_MSR_RI 6
`define UMS_MSR_CD 7

`define UMS_RST_MCR 8'h00
`define UMS_RST_SPR 8'hFF
`define UMS_RST_DLL 8'h01
`define UMS_RST_DLM 8'h00
`define UMS_RST_MASK 4'h0
`define UMS_RST_PINS 4'hF
`define UMS_READ_ZERO 8'h00
`define UMS_SETTLE_CNT 2'h3

`endif

// >>> inc/ums_pkg.sv
// Types shared by the modem status block
package ums_pkg;

  typedef enum logic [2:0] {
    UMS_TX_RUN = 3'b001,
    UMS_TX_DRAIN = 3'b010,
    UMS_TX_HALT = 3'b100
  } ums_tx_state_t;

endpackage

// >>> verification/ums_core_bench.sv
// Self-checking bench for the modem status block
`timescale 1ns/1ps
`define CHK(n, e, s) \
  begin \
    n_compared++; \
    if ((s) !== (e)) \
    begin \
      fails++; \
      $display("[FAIL] %s exp %h got %h", n, e, s); \
    end \
  end
module ums_core_bench;
  logic clk = 1'b0, rstn = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0, tx_busy = 1'b0;
  logic irq_output_select = 1'b0, tx_req = 1'b0;
  logic [3:0] addr = 4'h0, want = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, d;
  logic cts_n, dsr_n, ri_n, cd_n, int_out, int_oe, irq, loopback, tx_go, rts_n, dtr_n;
  logic [1:0] s_mdm;
  logic s_irq, s_go, s_oe, s_out;
  logic [15:0] divisor, s_div;
  int fails = 0, n_compared = 0;
  ums_core ums_core_i (.clk, .rstn, .por_n, .addr, .wdata, .wr, .rd, .rdata, .cts_n, .dsr_n,
    .ri_n, .cd_n, .irq_output_select, .rts_n, .dtr_n, .int_out, .int_oe, .irq, .divisor,
    .loopback, .tx_busy, .tx_req, .tx_go);
  ums_modem_peer ums_modem_peer_i (.clk, .want, .cts_n, .dsr_n, .ri_n, .cd_n);
  initial
    forever #2 clk = ~clk;
  task wrb(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Outputs are sampled mid-cycle so no edge race decides the result
  task rdb(input logic [3:0] a);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    {s_irq, s_go, s_oe, s_out, s_div, s_mdm} = {irq, tx_go, int_oe, int_out, divisor, rts_n, dtr_n};
    @(posedge clk);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task end_of_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task t_regs;
    rdb(4'h7);
    `CHK("spr rst", 8'hFF, d)
    rdb(4'h6);
    `CHK("msr rst", 8'h00, d)
    wrb(4'h7, 8'h5A);
    rdb(4'h7);
    `CHK("spr", 8'h5A, d)
    rdb(4'hF);
    `CHK("unmapped", 8'h00, d)
  endtask
  task t_div;
    wrb(4'h8, 8'h34);
    cyc(1);
    wrb(4'h9, 8'h12);
    irq_output_select <= 1'b1;
    rdb(4'h8);
    `CHK("divisor", 16'h1234, s_div)
    rstn <= 1'b0;
    cyc(1);
    @(negedge clk);
    `CHK("int rst", 2'b10, {int_oe, int_out})
    @(posedge clk);
    rstn <= 1'b1;
    cyc(4);
    rdb(4'h9);
    `CHK("div kept", 16'h1234, s_div)
    `CHK("int pin", 2'b10, {s_oe, s_out})
    irq_output_select <= 1'b0;
    por_n <= 1'b0;
    cyc(1);
    por_n <= 1'b1;
    rdb(4'h8);
    `CHK("div por", 16'h0001, s_div)
  endtask
  task t_pins;
    for (int i = 0; i < 4; i++)
    begin
      want <= 4'h1 << i;
      cyc(5);
      rdb(4'h6);
      `CHK("pins", 4'h1 << i, d[7:4])
    end
  endtask
  task t_loop;
    logic [1:0] map[4];
    map = '{2'd1, 2'd0, 2'd2, 2'd3};
    want <= 4'hF;
    for (int i = 0; i < 4; i++)
    begin
      wrb(4'h4, 8'h10 | (8'h01 << i));
      rdb(4'h6);
      `CHK("loop", 4'h1 << map[i], d[7:4])
      `CHK("loop pins", 2'b11, s_mdm)
    end
    wrb(4'h4, 8'h03);
    rdb(4'h4);
    `CHK("modem out", 10'h003, {s_mdm, d})
    wrb(4'h4, 8'h00);
    want <= 4'h0;
    cyc(6);
  endtask
  task t_irq;
    wrb(4'h6, 8'h0F);
    want <= 4'h1;
    cyc(5);
    rdb(4'h6);
    `CHK("masked", 5'h01, {s_irq, d[3:0]})
    wrb(4'hA, 8'h01);
    rdb(4'hA);
    `CHK("irq up", 1'b1, s_irq)
    wrb(4'h6, 8'h01);
    rdb(4'hA);
    `CHK("irq clr", 1'b0, s_irq)
  endtask
  task t_tx;
    tx_busy <= 1'b1;
    tx_req <= 1'b1;
    want <= 4'h0;
    cyc(5);
    rdb(4'hB);
    `CHK("drain", 2'b00, {d[0], s_go})
    tx_busy <= 1'b0;
    cyc(2);
    rdb(4'hB);
    `CHK("halt", 1'b1, d[0])
    want <= 4'h1;
    cyc(5);
    rdb(4'hB);
    `CHK("resume", 2'b01, {d[0], s_go})
    tx_req <= 1'b0;
  endtask
  initial
  begin
    cyc(19);
    @(negedge clk);
    `CHK("int float", 2'b00, {int_oe, int_out})
    @(posedge clk);
    rstn <= 1'b1;
    por_n <= 1'b1;
    cyc(1);
    t_regs();
    t_div();
    t_pins();
    t_loop();
    t_irq();
    t_tx();
    end_of_test();
  end
endmodule

// >>> verification/ums_core_properties.sv
// Port assertions for the modem status block
`timescale 1ns/1ps
module ums_core_properties (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic [3:0] addr, // Address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [7:0] rdata, // Read data
  input wire logic cts_n, // Clear-to-send
  input wire logic int_out, // Int pin
  input wire logic irq, // Interrupt
  input wire logic [15:0] divisor, // Divisor
  input wire logic loopback, // Loopback
  input wire logic tx_req, // Start request
  input wire logic tx_go // Start grant
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence spr_echo;
    wr && addr == 4'h7 ##1 rd && addr == 4'h7;
  endsequence
  // Four calm cycles cover the two-flop synchroniser delay
  sequence cts_calm;
    (!loopback && $stable(cts_n)) [*4];
  endsequence
  a_scratch_echo: assert property (spr_echo |=> rdata == $past(wdata, 2))
    else $error("scratch echo wrong");
  a_div_low: assert property (wr && addr == 4'h8 |=> divisor[7:0] == $past(wdata))
    else $error("divisor low byte wrong");
  a_div_high: assert property (wr && addr == 4'h9 |=> divisor[15:8] == $past(wdata))
    else $error("divisor high byte wrong");
  a_loop_enable: assert property (wr && addr == 4'h4 |=> loopback == $past(wdata[4]))
    else $error("loopback not from control bit");
  a_cts_status: assert property (cts_calm ##0 rd && addr == 4'h6
    |=> rdata[4] == !$past(cts_n, 2)) else $error("cts status wrong");
  a_cts_halt: assert property (cts_calm ##0 cts_n |-> !tx_go)
    else $error("start granted while clear-to-send off");
  a_go_request: assert property (tx_go |-> tx_req)
    else $error("start granted without request");
  a_int_pin_lag: assert property (1'b1 |=> int_out == $past(irq))
    else $error("int pin does not follow interrupt");
endmodule
bind ums_core ums_core_properties ums_core_properties_i (.clk, .rstn, .addr, .wdata, .wr, .rd,
  .rdata, .cts_n, .int_out, .irq, .divisor, .loopback, .tx_req, .tx_go);

// >>> verification/ums_modem_peer.sv
// Modem peer model driving the four handshake pins
`timescale 1ns/1ps
module ums_modem_peer (
  input wire logic clk, // Pacing clock
  input wire logic [3:0] want, // Assert cd, ri, dsr, cts
  output logic cts_n, // Clear-to-send
  output logic dsr_n, // Data-set-ready
  output logic ri_n, // Ring indicator
  output logic cd_n // Carrier detect
);
  // Falling edge keeps pin changes out of step with register sampling
  always @(negedge clk)
    {cd_n, ri_n, dsr_n, cts_n} <= ~want;
endmodule

// >>> verilog/ums_core.sv
// Modem status, loopback mapping, scratch, baud divisor and interrupt pin of one UART channel
//
// Operation
// - Clear-to-send high halts transmit after current character; low resumes it.
// - Status bit 4 is inverted clear-to-send; in loopback the request-to-send control bit.
// - Status bit 5 is inverted data-set-ready; in loopback the terminal-ready control bit.
// - Status bit 6 is inverted ring indicator; in loopback control bit 2.
// - Status bit 7 is inverted carrier detect; in loopback control bit 3.
// - Eight-bit scratch register, freely written and read, affecting nothing else.
// - Baud divisor is sixteen bits: high byte register above low byte register.
// - Divisor bytes load 0x00/0x01 only at power-up; reset pin leaves them alone.
// - Reset clears the four change flags; upper status bits read zero until the second edge after release.
// - Under reset the interrupt pin floats with select low, drives low with select high.
// - Each handshake input stays readable in its status bit as a general input while loopback is off.
// - Loopback is active whenever control register bit 4 is set.
`timescale 1ns/1ps
`include "ums_params.svh"
module ums_core
  import ums_pkg::*;
(
  input wire logic clk, // Register clock, 250 MHz
  input wire logic rstn, // Reset pin, asynchronous, active low
  input wire logic por_n, // Power-up reset, asynchronous, active low
  input wire logic [`UMS_ADDR_W-1:0] addr, // Register address
  input wire logic [`UMS_DATA_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [`UMS_DATA_W-1:0] rdata, // Read data, cycle after rd
  input wire logic cts_n, // Clear-to-send pin, active low
  input wire logic dsr_n, // Data-set-ready pin, active low
  input wire logic ri_n, // Ring indicator pin, active low
  input wire logic cd_n, // Carrier detect pin, active low
  input wire logic irq_output_select, // Interrupt pin select strap
  output logic rts_n, // Request-to-send pin, active low
  output logic dtr_n, // Data-terminal-ready pin, active low
  output logic int_out, // Interrupt pin output value
  output logic int_oe, // Interrupt pin output enable
  output logic irq, // Level interrupt, internal
  output logic [15:0] divisor, // Baud divisor to the rate generator
  output logic loopback, // Loopback mode to the serial engine
  input wire logic tx_busy, // Serial engine is shifting a character
  input wire logic tx_req, // Serial engine wants to start a character
  output logic tx_go // Start permission for the next character
);

  logic [7:0] mcr_r;
  logic [7:0] spr_r;
  logic [7:0] dll_r;
  logic [7:0] dlm_r;
  logic [3:0] mask_r;
  logic [3:0] delta_r;
  logic [3:0] delta_nxt;
  logic [3:0] hi_prev_r;
  logic [3:0] hi_now;
  logic [3:0] pin_sync;
  logic [3:0] pin_hi;
  logic [3:0] loop_hi;
  logic [3:0] change;
  logic [3:0] w1c;
  logic [7:0] msr_val;
  logic [7:0] rdata_r;
  logic [7:0] rd_mux;
  logic sel_sync;
  logic sel_meta_r;
  logic sel_r;
  logic stop_req;
  logic tx_paused;
  logic wr_mcr;
  logic wr_msr;
  logic wr_spr;
  logic wr_dll;
  logic wr_dlm;
  logic wr_mask;
  logic [1:0] settle_r;
  logic settled;

  // Order: cd, ri, dsr, cts so that index i maps to status bit i+4
  ums_sync2 #(
    .W(4),
    .RST_VAL(`UMS_RST_PINS)
  ) u_pin_sync (
    .clk(clk),
    .rstn(rstn),
    .d({cd_n, ri_n, dsr_n, cts_n}),
    .q(pin_sync)
  );

  // Strap synchroniser has no reset: the pin must follow the strap while reset is held
  always_ff @(posedge clk)
  begin
    sel_meta_r <= irq_output_select;
    sel_r <= sel_meta_r;
  end
  assign sel_sync = sel_r;

  assign loopback = mcr_r[`UMS_MCR_LOOP];

  // Write enables decoded once; a write to an unmapped offset enables nothing
  always_comb
  begin
    wr_mcr = 1'b0;
    wr_msr = 1'b0;
    wr_spr = 1'b0;
    wr_dll = 1'b0;
    wr_dlm = 1'b0;
    wr_mask = 1'b0;
    if (wr)
    begin
      unique case (addr)
        `UMS_OFF_MCR: wr_mcr = 1'b1;
        `UMS_OFF_MSR: wr_msr = 1'b1;
        `UMS_OFF_SPR: wr_spr = 1'b1;
        `UMS_OFF_DLL: wr_dll = 1'b1;
        `UMS_OFF_DLM: wr_dlm = 1'b1;
        `UMS_OFF_MASK: wr_mask = 1'b1;
        default: wr_mask = 1'b0;
      endcase
    end
  end

  assign pin_hi = ~pin_sync;

  assign loop_hi = {mcr_r[`UMS_MCR_OUT2], mcr_r[`UMS_MCR_OUT1],
                    mcr_r[`UMS_MCR_DTR], mcr_r[`UMS_MCR_RTS]};

  always_comb
  begin
    hi_now = pin_hi;
    if (loopback)
      hi_now = loop_hi;
  end

  // Status byte: upper nibble bit by bit, lower nibble the change flags
  always_comb
  begin
    msr_val = 8'h00;
    msr_val[`UMS_MSR_CTS] = hi_now[0];
    msr_val[`UMS_MSR_DSR] = hi_now[1];
    msr_val[`UMS_MSR_RI] = hi_now[2];
    msr_val[`UMS_MSR_CD] = hi_now[3];
    msr_val[3:0] = delta_r;
  end

  // Synchronisers show idle for two edges after release; a pin already asserted
  // then would look like a change, so flags wait until the view has settled
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      settle_r <= 2'h0;
    else if (settle_r != `UMS_SETTLE_CNT)
      settle_r <= settle_r + 2'h1;
  end

  assign settled = (settle_r == `UMS_SETTLE_CNT);

  // Ring flags only the end of ringing, the others any change
  assign change[0] = settled & (hi_now[0] ^ hi_prev_r[0]);
  assign change[1] = settled & (hi_now[1] ^ hi_prev_r[1]);
  assign change[2] = settled & hi_prev_r[2] & ~hi_now[2];
  assign change[3] = settled & (hi_now[3] ^ hi_prev_r[3]);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hi_prev_r <= 4'h0;
    else
      hi_prev_r <= hi_now;
  end

  assign w1c = wr_msr ? wdata[3:0] : 4'h0;

  // Set beats clear so a change in the clearing cycle is kept
  always_comb
  begin
    delta_nxt = (delta_r & ~w1c) | change;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      delta_r <= 4'h0;
    else
      delta_r <= delta_nxt;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mask_r <= `UMS_RST_MASK;
    else if (wr_mask)
      mask_r <= wdata[3:0];
  end

  assign irq = |(delta_r & mask_r);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mcr_r <= `UMS_RST_MCR;
    else if (wr_mcr)
      mcr_r <= wdata & `UMS_MCR_MASK;
  end

  // In loopback the modem outputs rest inactive; the control bits go inward
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rts_n <= 1'b1;
    else
      rts_n <= ~(mcr_r[`UMS_MCR_RTS] & ~loopback);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dtr_n <= 1'b1;
    else
      dtr_n <= ~(mcr_r[`UMS_MCR_DTR] & ~loopback);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      spr_r <= `UMS_RST_SPR;
    else if (wr_spr)
      spr_r <= wdata;
  end

  // Divisor is held only by the power-up reset
  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      dll_r <= `UMS_RST_DLL;
    else if (wr_dll)
      dll_r <= wdata;
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      dlm_r <= `UMS_RST_DLM;
    else if (wr_dlm)
      dlm_r <= wdata;
  end

  assign divisor = {dlm_r, dll_r};

  // Clear-to-send as seen by the transmitter follows the loopback mapping
  assign stop_req = ~hi_now[0];

  ums_tx_pacer u_pacer (
    .clk(clk),
    .rstn(rstn),
    .stop_req(stop_req),
    .tx_busy(tx_busy),
    .tx_req(tx_req),
    .tx_go(tx_go),
    .tx_paused(tx_paused)
  );

  // Pin enable: strap high forces drive, otherwise the output-enable bit.
  // No reset, so the strap decides under reset too; the enable is unknown
  // until three edges have passed after power-up.
  always_ff @(posedge clk)
  begin
    int_oe <= sel_sync | mcr_r[`UMS_MCR_OUT2];
  end

  // Value is low under reset so a driven pin shows no request
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      int_out <= 1'b0;
    else
      int_out <= irq;
  end

  always_comb
  begin
    rd_mux = `UMS_READ_ZERO;
    unique case (addr)
      `UMS_OFF_MCR: rd_mux = mcr_r;
      `UMS_OFF_MSR: rd_mux = msr_val;
      `UMS_OFF_SPR: rd_mux = spr_r;
      `UMS_OFF_DLL: rd_mux = dll_r;
      `UMS_OFF_DLM: rd_mux = dlm_r;
      `UMS_OFF_MASK: rd_mux = {4'h0, mask_r};
      `UMS_OFF_TXST: rd_mux = {7'h00, tx_paused};
      default: rd_mux = `UMS_READ_ZERO;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= 8'h00;
    else if (rd)
      rdata_r <= rd_mux;
    else
      rdata_r <= 8'h00;
  end

  assign rdata = rdata_r;

endmodule

// >>> verilog/ums_sync2.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module ums_sync2 #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk, // Register clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// >>> verilog/ums_tx_pacer.sv
// Transmit pacing on clear-to-send: lets a character finish, then holds off
`timescale 1ns/1ps
module ums_tx_pacer
  import ums_pkg::*;
(
  input wire logic clk, // Register clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic stop_req, // High: peer asks the transmitter to stop
  input wire logic tx_busy, // Serial engine is shifting a character
  input wire logic tx_req, // Serial engine wants to start a character
  output logic tx_go, // Start permission for the next character
  output logic tx_paused // Transmitter is held off
);

  ums_tx_state_t state_r;
  ums_tx_state_t state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      UMS_TX_RUN:
      begin
        if (stop_req && tx_busy)
          state_nxt = UMS_TX_DRAIN;
        else if (stop_req)
          state_nxt = UMS_TX_HALT;
      end
      UMS_TX_DRAIN:
      begin
        if (!stop_req)
          state_nxt = UMS_TX_RUN;
        else if (!tx_busy)
          state_nxt = UMS_TX_HALT;
      end
      UMS_TX_HALT:
      begin
        if (!stop_req)
          state_nxt = UMS_TX_RUN;
      end
      default:
        state_nxt = UMS_TX_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= UMS_TX_RUN;
    else
      state_r <= state_nxt;
  end

  // A character in flight is never cut; only new starts are withheld
  assign tx_go = tx_req && (state_r == UMS_TX_RUN) && !stop_req;
  assign tx_paused = (state_r == UMS_TX_HALT);

endmodule
